// file: common/astx_pkg.sv
// Package for the asynchronous serial transmitter with break support
package astx_pkg;
  // Register offsets (byte addresses)
  localparam logic [3:0] ADDR_TX_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_RX_CTRL   = 4'h1;
  localparam logic [3:0] ADDR_TX_HOLD   = 4'h2;
  localparam logic [3:0] ADDR_RX_DATA   = 4'h3;
  localparam logic [3:0] ADDR_FLAGS     = 4'h4;
  localparam logic [3:0] ADDR_IRQ_EN    = 4'h5;
  localparam logic [3:0] ADDR_BAUD_LO   = 4'h6;
  localparam logic [3:0] ADDR_BAUD_HI   = 4'h7;
  localparam logic [3:0] ADDR_BAUD_CFG  = 4'h8;
  localparam logic [3:0] ADDR_RX_STAT   = 4'h9;
  // Transmit control/status fields
  localparam int TXC_NINTH_DATA = 0;
  localparam int TXC_SHIFT_EMPTY = 1;
  localparam int TXC_SEND_BREAK = 3;
  localparam int TXC_SYNC_SEL   = 4;
  localparam int TXC_TX_ENABLE  = 5;
  localparam int TXC_NINE_BIT   = 6;
  // Receive control fields
  localparam int RXC_PORT_EN    = 7;
  // Flag/enable fields
  localparam int FLG_TX_EMPTY   = 4;
  localparam int FLG_RX_DONE    = 5;
  // Receive status and baud configuration fields
  localparam int RXS_FRAME_ERR  = 2;
  localparam int BCFG_WIDE      = 3;
  // Reset values
  localparam logic [7:0] TXC_RESET  = 8'h02;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;
  // Character geometry
  localparam logic [3:0] BREAK_ZEROS = 4'hC;
  localparam logic [3:0] DATA_BITS_8 = 4'h8;
  localparam logic [3:0] DATA_BITS_9 = 4'h9;
  // Write-to-flag latency: flag valid in second cycle after write
  localparam int FLAG_LAG_CYCLES = 2;

  // Transmit state machine
  typedef enum logic [3:0] {
    ASTX_IDLE  = 4'b0001,
    ASTX_START = 4'b0010,
    ASTX_DATA  = 4'b0100,
    ASTX_STOP  = 4'b1000
  } astx_state_t;

  // Register bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } astx_bus_req_t;

  // Receive-side status presented by the receiver path
  typedef struct packed {
    logic       done;
    logic       frame_err;
    logic [7:0] data;
  } astx_rx_stat_t;
endpackage

// file: core/astx_baud_gen.sv
// Baud tick generator, 8-bit or 16-bit divisor
`timescale 1ns/100ps
module astx_baud_gen
  import astx_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Control
  input  wire logic        run,
  input  wire logic        wide,
  input  wire logic [15:0] divisor,
  // Tick out
  output logic             tick
);
  logic [15:0] count_r;
  logic [15:0] limit;

  // Narrow mode ignores the high divisor byte
  assign limit = wide ? divisor : {8'h00, divisor[7:0]};

  // Tick while the count sits at the limit; a registered tick would stretch the first bit by a cycle
  assign tick = run & (count_r >= limit);

  // Counter restarts whenever the transmitter is not running
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_r <= 16'h0000;
    end else if (!run || tick) begin
      count_r <= 16'h0000;
    end else begin
      count_r <= count_r + 16'h0001;
    end
  end
endmodule

// file: core/astx_core.sv
// Asynchronous serial transmitter with break generation and register port
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
// Notes on behaviour
// R1: Line NRZ, idles at mark level
// R2: Start, eight or nine data, stop
// R3: Each bit lasts one baud period
// R4: Data sent least significant bit first
// R5: Shared format and baud, independent halves
// R6: No hardware parity; ninth bit carries it
// R7: Transmit needs enable, async, port enable
// R8: Port enable drives transmit pin output
// R9: Port enable forces receive pin input
// R10: Holding write starts or queues character
// R11: Queued char moves right after stop
// R12: Empty flag set unless char queued
// R13: Empty flag valid second cycle after write
// R14: Empty flag read-only to software
// R15: Flag ignores enable; request gated
// R16: Software clears enable at last character
// R17: Break: start, twelve zeros, stop
// R18: Write during send-break starts break
// R19: Send-break self-clears after break stop
// R20: Shift-empty bit tracks break too
// R21: Header: dummy write then sync write
// R22: Break seen: done, framing error, zero
module astx_core
  import astx_pkg::*;
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          reset,
  // Register port
  input  wire astx_bus_req_t bus_req,
  output logic [7:0]         rdata,
  // Receiver path status
  input  wire astx_rx_stat_t rx_stat,
  // Pins
  input  wire logic          serial_in_pin_i,
  output logic               serial_out_pin_o,
  output logic               serial_out_pin_oe,
  output logic               serial_in_pin_oe,
  // Port latch pass-through when serial port is off
  input  wire logic          tx_latch,
  input  wire logic          tx_dir_bit,
  input  wire logic          rx_latch,
  input  wire logic          rx_dir_bit,
  output logic               serial_in_pin_o,
  // Status outputs
  output logic               transmit_buffer_empty_flag,
  output logic               tx_irq,
  output logic               break_received
);
  // Control registers
  logic [7:0]  tx_ctrl_r;
  logic [7:0]  rx_ctrl_r;
  logic [7:0]  irq_en_r;
  logic [7:0]  baud_lo_r;
  logic [7:0]  baud_hi_r;
  logic [7:0]  baud_cfg_r;
  // Holding buffer
  logic [7:0]  hold_data_r;
  logic        hold_ninth_r;
  logic        hold_full_r;
  logic        hold_break_r;
  // Shift register and sequencing
  astx_state_t state_r;
  logic [8:0]  shift_r;
  logic [3:0]  bit_cnt_r;
  logic [3:0]  bit_total_r;
  logic        shift_is_break_r;
  logic        line_r;
  // Flag lag pipe and sampled receive pin
  logic [1:0]  wr_lag_r;
  logic        pin_in_r;

  logic transmit_enable;
  logic serial_port_enable;
  logic send_break_request;
  logic tx_active;
  logic baud_tick;
  logic hold_wr;
  logic load_shift;
  logic stop_done;

  // Field decode used by several processes
  function automatic logic is_reg(input logic [3:0] a, input logic [3:0] r);
    is_reg = (a == r);
  endfunction

  assign transmit_enable    = tx_ctrl_r[TXC_TX_ENABLE];
  assign serial_port_enable = rx_ctrl_r[RXC_PORT_EN];
  assign send_break_request = tx_ctrl_r[TXC_SEND_BREAK];
  assign tx_active = transmit_enable & ~tx_ctrl_r[TXC_SYNC_SEL] & serial_port_enable; // R7
  assign hold_wr   = bus_req.wr & is_reg(bus_req.addr, ADDR_TX_HOLD) & tx_active; // R10
  // Load when shifter idle, or in the cycle the stop bit completes
  assign stop_done  = (state_r == ASTX_STOP) & baud_tick;
  assign load_shift = hold_full_r & ((state_r == ASTX_IDLE) | stop_done); // R11

  // Shared baud generator; one divisor for both halves
  astx_baud_gen u_baud (
    .clk     (clk),
    .reset   (reset),
    .run     (tx_active & (state_r != ASTX_IDLE)),
    .wide    (baud_cfg_r[BCFG_WIDE]),
    .divisor ({baud_hi_r, baud_lo_r}),
    .tick    (baud_tick)
  ); // R3 R5

  // Software-writable control registers; shift-empty bit kept by hardware
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_ctrl_r  <= TXC_RESET;
      rx_ctrl_r  <= ZERO_BYTE;
      irq_en_r   <= ZERO_BYTE;
      baud_lo_r  <= ZERO_BYTE;
      baud_hi_r  <= ZERO_BYTE;
      baud_cfg_r <= ZERO_BYTE;
    end else begin
      if (bus_req.wr && is_reg(bus_req.addr, ADDR_TX_CTRL)) begin
        tx_ctrl_r[TXC_NINTH_DATA] <= bus_req.wdata[TXC_NINTH_DATA];
        tx_ctrl_r[TXC_SYNC_SEL]   <= bus_req.wdata[TXC_SYNC_SEL];
        tx_ctrl_r[TXC_TX_ENABLE]  <= bus_req.wdata[TXC_TX_ENABLE];
        tx_ctrl_r[TXC_NINE_BIT]   <= bus_req.wdata[TXC_NINE_BIT];
        tx_ctrl_r[7]              <= bus_req.wdata[7];
        tx_ctrl_r[2]              <= bus_req.wdata[2];
      end
      // Hardware clear after break stop wins over a software write
      if (stop_done && shift_is_break_r) begin
        tx_ctrl_r[TXC_SEND_BREAK] <= 1'b0; // R19
      end else if (bus_req.wr && is_reg(bus_req.addr, ADDR_TX_CTRL)) begin
        tx_ctrl_r[TXC_SEND_BREAK] <= bus_req.wdata[TXC_SEND_BREAK];
      end
      tx_ctrl_r[TXC_SHIFT_EMPTY] <= (state_r == ASTX_IDLE) & ~load_shift; // R20
      if (bus_req.wr && is_reg(bus_req.addr, ADDR_RX_CTRL)) begin
        rx_ctrl_r <= bus_req.wdata;
      end
      if (bus_req.wr && is_reg(bus_req.addr, ADDR_IRQ_EN)) begin
        irq_en_r <= bus_req.wdata;
      end
      if (bus_req.wr && is_reg(bus_req.addr, ADDR_BAUD_LO)) begin
        baud_lo_r <= bus_req.wdata;
      end
      if (bus_req.wr && is_reg(bus_req.addr, ADDR_BAUD_HI)) begin
        baud_hi_r <= bus_req.wdata;
      end
      if (bus_req.wr && is_reg(bus_req.addr, ADDR_BAUD_CFG)) begin
        baud_cfg_r <= bus_req.wdata;
      end
    end
  end

  // Holding buffer; a write while full overwrites the queued character
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hold_data_r  <= ZERO_BYTE;
      hold_ninth_r <= 1'b0;
      hold_full_r  <= 1'b0;
      hold_break_r <= 1'b0;
    end else if (!tx_active) begin
      hold_full_r  <= 1'b0;
      hold_break_r <= 1'b0;
    end else if (hold_wr) begin
      hold_data_r  <= bus_req.wdata;
      hold_ninth_r <= tx_ctrl_r[TXC_NINTH_DATA]; // R6
      hold_full_r  <= 1'b1; // R10
      // Break only if not already owed by the shifter
      hold_break_r <= send_break_request & ~shift_is_break_r &
                      ~(hold_full_r & hold_break_r); // R18
    end else if (load_shift) begin
      hold_full_r  <= 1'b0;
      hold_break_r <= 1'b0;
    end
  end

  // Transmit sequencer: start, data or break zeros, one stop bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r          <= ASTX_IDLE;
      shift_r          <= 9'h000;
      bit_cnt_r        <= 4'h0;
      bit_total_r      <= DATA_BITS_8;
      shift_is_break_r <= 1'b0;
    end else if (!tx_active) begin
      state_r          <= ASTX_IDLE;
      shift_is_break_r <= 1'b0;
    end else if (load_shift) begin
      state_r          <= ASTX_START; // R11
      bit_cnt_r        <= 4'h0;
      shift_is_break_r <= hold_break_r;
      if (hold_break_r) begin
        shift_r     <= 9'h000; // R18
        bit_total_r <= BREAK_ZEROS; // R17
      end else begin
        shift_r     <= {hold_ninth_r, hold_data_r};
        bit_total_r <= tx_ctrl_r[TXC_NINE_BIT] ? DATA_BITS_9 : DATA_BITS_8; // R2
      end
    end else if (baud_tick) begin
      case (state_r)
        ASTX_START: begin
          state_r <= ASTX_DATA;
        end
        ASTX_DATA: begin
          shift_r   <= {1'b0, shift_r[8:1]}; // R4
          bit_cnt_r <= bit_cnt_r + 4'h1;
          if (bit_cnt_r == bit_total_r - 4'h1) begin
            state_r <= ASTX_STOP;
          end
        end
        ASTX_STOP: begin
          state_r          <= ASTX_IDLE;
          shift_is_break_r <= 1'b0;
        end
        default: begin
          state_r <= ASTX_IDLE;
        end
      endcase
    end
  end

  // Line level from the sequencer; mark whenever idle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      line_r <= 1'b1;
    end else begin
      case (state_r)
        ASTX_START: line_r <= 1'b0; // R2
        ASTX_DATA:  line_r <= shift_r[0]; // R1
        default:    line_r <= 1'b1; // R1
      endcase
    end
  end

  // Pin ownership: serial logic overrides port direction when enabled
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      serial_out_pin_o  <= 1'b1;
      serial_out_pin_oe <= 1'b0;
      serial_in_pin_o   <= 1'b0;
      serial_in_pin_oe  <= 1'b0;
      pin_in_r          <= 1'b1;
    end else begin
      pin_in_r <= serial_in_pin_i;
      if (serial_port_enable) begin
        serial_out_pin_o  <= line_r;
        serial_out_pin_oe <= 1'b1; // R8
        serial_in_pin_o   <= 1'b0;
        serial_in_pin_oe  <= 1'b0; // R9
      end else begin
        serial_out_pin_o  <= tx_latch;
        serial_out_pin_oe <= ~tx_dir_bit;
        serial_in_pin_o   <= rx_latch;
        serial_in_pin_oe  <= ~rx_dir_bit;
      end
    end
  end

  // Write lag so the flag settles two cycles after a holding write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wr_lag_r <= 2'b00;
    end else begin
      wr_lag_r <= {wr_lag_r[0], hold_wr};
    end
  end

  // Empty flag from buffer state, or from transmit enable while inactive; no software path
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      transmit_buffer_empty_flag <= 1'b0;
      tx_irq                     <= 1'b0;
    end else begin
      if (!tx_active) begin
        transmit_buffer_empty_flag <= transmit_enable; // R12
      end else if (wr_lag_r != 2'b00) begin
        transmit_buffer_empty_flag <= transmit_buffer_empty_flag; // R13
      end else begin
        transmit_buffer_empty_flag <= ~hold_full_r; // R12 R14
      end
      tx_irq <= transmit_buffer_empty_flag & irq_en_r[FLG_TX_EMPTY]; // R15
    end
  end

  // Break detection on received status
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      break_received <= 1'b0;
    end else begin
      break_received <= rx_stat.done & rx_stat.frame_err & (rx_stat.data == ZERO_BYTE); // R22
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= ZERO_BYTE;
    end else if (!bus_req.rd) begin
      rdata <= ZERO_BYTE;
    end else if (is_reg(bus_req.addr, ADDR_TX_CTRL)) begin
      rdata <= tx_ctrl_r;
    end else if (is_reg(bus_req.addr, ADDR_RX_CTRL)) begin
      rdata <= rx_ctrl_r;
    end else if (is_reg(bus_req.addr, ADDR_RX_DATA)) begin
      rdata <= rx_stat.data;
    end else if (is_reg(bus_req.addr, ADDR_FLAGS)) begin
      rdata <= {2'b00, rx_stat.done, transmit_buffer_empty_flag, 4'h0};
    end else if (is_reg(bus_req.addr, ADDR_IRQ_EN)) begin
      rdata <= irq_en_r;
    end else if (is_reg(bus_req.addr, ADDR_BAUD_LO)) begin
      rdata <= baud_lo_r;
    end else if (is_reg(bus_req.addr, ADDR_BAUD_HI)) begin
      rdata <= baud_hi_r;
    end else if (is_reg(bus_req.addr, ADDR_BAUD_CFG)) begin
      rdata <= baud_cfg_r;
    end else if (is_reg(bus_req.addr, ADDR_RX_STAT)) begin
      rdata <= {5'h00, rx_stat.frame_err, 1'b0, pin_in_r};
    end else begin
      rdata <= ZERO_BYTE;
    end
  end
endmodule

// file: testbench/astx_core_monitor.sv
// Port checker for the serial transmitter core
`timescale 1ns/100ps
module astx_core_monitor
  import astx_pkg::*;
(
  // Clock and reset
  input wire logic          clk,
  input wire logic          reset,
  // Watched ports
  input wire astx_bus_req_t bus_req,
  input wire astx_rx_stat_t rx_stat,
  input wire logic          serial_out_pin_o,
  input wire logic          serial_out_pin_oe,
  input wire logic          serial_in_pin_oe,
  input wire logic          transmit_buffer_empty_flag,
  input wire logic          tx_irq,
  input wire logic          break_received
);
  logic       pen_r;
  logic       ten_r;
  logic [3:0] pen_age_r;
  logic [5:0] off_age_r;
  wire        hold_wr = bus_req.wr && (bus_req.addr == ADDR_TX_HOLD);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Shadow enables from bus writes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pen_r <= 1'b0;
      ten_r <= 1'b0;
    end else if (bus_req.wr && bus_req.addr == ADDR_RX_CTRL) begin
      pen_r <= bus_req.wdata[RXC_PORT_EN];
    end else if (bus_req.wr && bus_req.addr == ADDR_TX_CTRL) begin
      ten_r <= bus_req.wdata[TXC_TX_ENABLE];
    end
  end
  // Ages mask the pin switch-over and frames still draining
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pen_age_r <= 4'h0;
      off_age_r <= 6'h00;
    end else begin
      pen_age_r <= !pen_r ? 4'h0 : (pen_age_r == 4'hF ? pen_age_r : pen_age_r + 4'h1);
      off_age_r <= ten_r ? 6'h00 : (off_age_r == 6'h3F ? off_age_r : off_age_r + 6'h01);
    end
  end
  property p_irq_gated;
    tx_irq |-> $past(transmit_buffer_empty_flag);
  endproperty
  a_irq_gated: assert property (p_irq_gated) else $error("irq without empty flag");
  property p_break_seen;
    break_received == $past(rx_stat.done && rx_stat.frame_err && rx_stat.data == ZERO_BYTE);
  endproperty
  a_break_seen: assert property (p_break_seen) else $error("break detect wrong");
  property p_rx_input;
    pen_r && $past(pen_r) |-> !serial_in_pin_oe;
  endproperty
  a_rx_input: assert property (p_rx_input) else $error("receive pin driven");
  property p_tx_drive;
    pen_r && $past(pen_r) |-> serial_out_pin_oe;
  endproperty
  a_tx_drive: assert property (p_tx_drive) else $error("transmit pin not driven");
  property p_bit_len;
    pen_age_r == 4'hF && $changed(serial_out_pin_o) |=> $stable(serial_out_pin_o) [*3];
  endproperty
  a_bit_len: assert property (p_bit_len) else $error("bit shorter than period");
  property p_flag_lag;
    hold_wr |=> $stable(transmit_buffer_empty_flag);
  endproperty
  a_flag_lag: assert property (p_flag_lag) else $error("flag moved right after write");
  property p_flag_off;
    off_age_r > 6'h02 |-> !transmit_buffer_empty_flag;
  endproperty
  a_flag_off: assert property (p_flag_off) else $error("flag set while disabled");
  property p_line_idle;
    pen_age_r == 4'hF && off_age_r == 6'h3F |-> serial_out_pin_o;
  endproperty
  a_line_idle: assert property (p_line_idle) else $error("line not at mark");
  // Main scenarios
  c_break: cover property (break_received);
  c_irq: cover property (tx_irq);
  c_queued: cover property ($fell(transmit_buffer_empty_flag));
endmodule
bind astx_core astx_core_monitor u_astx_core_monitor (
  .clk                        (clk),
  .reset                      (reset),
  .bus_req                    (bus_req),
  .rx_stat                    (rx_stat),
  .serial_out_pin_o           (serial_out_pin_o),
  .serial_out_pin_oe          (serial_out_pin_oe),
  .serial_in_pin_oe           (serial_in_pin_oe),
  .transmit_buffer_empty_flag (transmit_buffer_empty_flag),
  .tx_irq                     (tx_irq),
  .break_received             (break_received)
);

// file: testbench/astx_far_node.sv
// Remote serial node: decodes frames seen on the line
`timescale 1ns/100ps
module astx_far_node #(
  parameter int BIT_CYC = 4
) (
  // Clock
  input wire logic   clk,
  // Lines
  input wire logic   line,
  output logic       back_line,
  // Decoder setup and result
  input wire logic [3:0] nbits,
  output logic [11:0]    got_data,
  output logic           got_stop,
  output int             got_cnt
);
  logic [11:0] sh;
  int          n;
  // Quiet node rests its own line at mark
  assign back_line = 1'b1;
  // Mid-bit sampling; start requalified so glitches are ignored
  initial begin
    got_data = 12'h000;
    got_stop = 1'b0;
    got_cnt = 0;
    forever begin
      @(negedge line);
      repeat (BIT_CYC / 2) @(posedge clk);
      if (!line) begin
        n = nbits;
        sh = 12'h000;
        for (int i = 0; i < n; i++) begin
          repeat (BIT_CYC) @(posedge clk);
          sh[i] = line;
        end
        repeat (BIT_CYC) @(posedge clk);
        got_stop = line;
        got_data = sh;
        got_cnt++;
      end
    end
  end
endmodule

// file: testbench/astx_core_bench.sv
// Self-checking bench for the serial transmitter core
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_count++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module astx_core_bench
  import astx_pkg::*;
;
  logic          clk;
  logic          reset;
  astx_bus_req_t bus_req;
  astx_rx_stat_t rx_stat;
  logic [7:0]    rdata;
  logic [7:0]    rv;
  logic          so_o;
  logic          so_oe;
  logic          si_oe;
  logic          flag;
  logic          irq;
  logic          brk;
  logic          back;
  logic          si_o;
  logic          lat_tx;
  logic          dir_tx;
  logic          lat_rx;
  logic          dir_rx;
  logic [3:0]    nbits;
  logic [11:0]   got_data;
  logic          got_stop;
  int            got_cnt;
  int            last;
  int            err_count;
  int            checked;
  // Design; port latch and direction bits driven by the bench
  astx_core u_astx_core (
    .clk(clk), .reset(reset), .bus_req(bus_req), .rdata(rdata), .rx_stat(rx_stat),
    .serial_in_pin_i(back), .serial_out_pin_o(so_o), .serial_out_pin_oe(so_oe),
    .serial_in_pin_oe(si_oe), .tx_latch(lat_tx), .tx_dir_bit(dir_tx), .rx_latch(lat_rx),
    .rx_dir_bit(dir_rx), .serial_in_pin_o(si_o), .transmit_buffer_empty_flag(flag),
    .tx_irq(irq), .break_received(brk)
  );
  // Far node, divisor 3 gives four cycles a bit
  astx_far_node #(.BIT_CYC(4)) u_astx_far_node (
    .clk(clk), .line(so_o), .back_line(back), .nbits(nbits),
    .got_data(got_data), .got_stop(got_stop), .got_cnt(got_cnt)
  );
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus_req <= '0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    bus_req <= '0;
    #1;
    rv = rdata;
  endtask
  // Bounded wait for the next decoded frame
  task automatic frame(input logic [11:0] e, input string nm);
    int t;
    t = 0;
    while (got_cnt == last && t < 400) begin
      @(posedge clk);
      t++;
    end
    last = got_cnt;
    `CHK(nm, {1'b1, e}, {got_stop, got_data})
  endtask
  task automatic end_of_test();
    if (err_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Run needs about 500 cycles
  initial begin
    #1000000;
    err_count++;
    end_of_test();
  end
  initial begin
    reset = 1'b1;
    bus_req = '0;
    rx_stat = '0;
    nbits = 4'h8;
    lat_tx = 1'b1;
    dir_tx = 1'b1;
    lat_rx = 1'b1;
    dir_rx = 1'b0;
    last = 0;
    err_count = 0;
    checked = 0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rd(ADDR_TX_CTRL);
    `CHK("tx_ctrl reset", TXC_RESET, rv)
    rd(4'hF);
    `CHK("unmapped", ZERO_BYTE, rv)
    `CHK("latch rx oe", 1'b1, si_oe)
    `CHK("latch rx", 1'b1, si_o)
    `CHK("latch tx oe", 1'b0, so_oe)
    wr(ADDR_BAUD_LO, 8'h03);
    wr(ADDR_BAUD_HI, 8'h01);
    wr(ADDR_BAUD_CFG, 8'h00);
    wr(ADDR_RX_CTRL, 8'h80);
    tick(70);
    `CHK("tx oe", 1'b1, so_oe)
    `CHK("rx oe", 1'b0, si_oe)
    `CHK("flag off", 1'b0, flag)
    rd(ADDR_RX_STAT);
    `CHK("rx pin", 1'b1, rv[0])
    wr(ADDR_TX_CTRL, 8'h20);
    tick(3);
    `CHK("flag on", 1'b1, flag)
    wr(ADDR_FLAGS, 8'h00);
    rd(ADDR_FLAGS);
    `CHK("flag ro", 1'b1, rv[FLG_TX_EMPTY])
    wr(ADDR_TX_HOLD, 8'hA5);
    tick(4);
    wr(ADDR_TX_HOLD, 8'h3C);
    tick(3);
    `CHK("flag queued", 1'b0, flag)
    wr(ADDR_IRQ_EN, 8'h10);
    tick(2);
    `CHK("irq gated", 1'b0, irq)
    frame(12'h0A5, "frame a5");
    frame(12'h03C, "frame 3c");
    tick(2);
    `CHK("irq on", 1'b1, irq)
    wr(ADDR_IRQ_EN, 8'h00);
    tick(2);
    `CHK("irq off", 1'b0, irq)
    `CHK("flag kept", 1'b1, flag)
    wr(ADDR_TX_CTRL, 8'h61);
    nbits <= 4'h9;
    wr(ADDR_TX_HOLD, 8'h5A);
    frame(12'h15A, "nine bit");
    wr(ADDR_TX_CTRL, 8'h28);
    nbits <= 4'hC;
    wr(ADDR_TX_HOLD, 8'hFF);
    tick(4);
    wr(ADDR_TX_HOLD, 8'h55);
    rd(ADDR_TX_CTRL);
    `CHK("break busy", 8'h28, rv)
    frame(12'h000, "break");
    nbits <= 4'h8;
    frame(12'h055, "sync");
    tick(12);
    rd(ADDR_TX_CTRL);
    `CHK("break done", 8'h22, rv)
    rx_stat <= '{done: 1'b1, frame_err: 1'b1, data: 8'h00};
    tick(2);
    `CHK("break seen", 1'b1, brk)
    rx_stat <= '{done: 1'b1, frame_err: 1'b1, data: 8'h01};
    tick(2);
    `CHK("not break", 1'b0, brk)
    rd(ADDR_RX_DATA);
    `CHK("rx data", 8'h01, rv)
    rd(ADDR_RX_STAT);
    `CHK("frame err", 1'b1, rv[RXS_FRAME_ERR])
    rx_stat <= '0;
    wr(ADDR_TX_CTRL, 8'h30);
    wr(ADDR_TX_HOLD, 8'h77);
    tick(80);
    `CHK("sync mode", last, got_cnt)
    // Wide divisor stretches the start bit far past the narrow period
    wr(ADDR_BAUD_CFG, 8'h08);
    wr(ADDR_TX_CTRL, 8'h20);
    wr(ADDR_TX_HOLD, 8'hFF);
    tick(20);
    `CHK("wide start", 1'b0, so_o)
    // Reset in mid-frame returns line to mark and flag low
    reset <= 1'b1;
    tick(2);
    `CHK("reset line", 1'b1, so_o)
    `CHK("reset flag", 1'b0, flag)
    reset <= 1'b0;
    rd(ADDR_TX_CTRL);
    `CHK("reset ctrl", TXC_RESET, rv)
    end_of_test();
  end
endmodule
